// [hw/kcsr_pkg.sv]
// package: register map, field positions and carrier structs for the csr slice
package kcsr_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;

  // word addresses
  localparam logic [10:0] ADDR_FEC_CTRL   = 11'h4b0;
  localparam logic [10:0] ADDR_SEQ_STAT   = 11'h4b1;
  localparam logic [10:0] ADDR_FEC_INJ    = 11'h4b2;
  localparam logic [10:0] ADDR_RSVD_LO    = 11'h4b5;
  localparam logic [10:0] ADDR_RSVD_HI    = 11'h4bf;
  localparam logic [10:0] ADDR_AN_CTRL    = 11'h4c0;
  localparam logic [10:0] ADDR_AN_ACT     = 11'h4c1;

  // fec_control_word fields
  localparam int B_SEQ_RESTART = 0;
  localparam int B_FEC_EN      = 16;
  localparam int B_FEC_ERR_IND = 17;
  localparam int B_FEC_REQ     = 18;

  // sequencer_fec_status fields
  localparam int B_LINK_READY  = 0;
  localparam int B_AN_TMO      = 1;
  localparam int B_LT_TMO      = 2;
  localparam int B_MODE_LO     = 8;
  localparam int MODE_W        = 6;
  localparam int B_FEC_ABIL    = 16;
  localparam int B_ERRIND_ABIL = 17;

  // fec_error_inject fields
  localparam int B_FEC_INJ     = 11;

  // autoneg_control fields
  localparam int B_AN_EN       = 0;
  localparam int B_BASE_PG     = 1;
  localparam int B_NEXT_PG     = 2;
  localparam int B_RFAULT      = 3;
  localparam int B_NONCE       = 4;
  localparam int B_OVERRIDE    = 5;

  // autoneg_actions fields
  localparam int B_AN_RESET    = 0;
  localparam int B_TX_RESTART  = 4;
  localparam int B_NP_READY    = 8;

  localparam logic       AN_EN_RST = 1'b1;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // management write/read request
  typedef struct packed {
    logic [10:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } kcsr_req_t;

  // status arriving from the sequencer
  typedef struct packed {
    logic              link_ready;
    logic              an_timeout;
    logic              lt_timeout;
    logic [5:0]        mode;
  } kcsr_seq_t;

  // one-cycle action pulses
  typedef struct packed {
    logic seq_restart;
    logic fec_inject;
    logic an_reset;
    logic tx_restart;
    logic np_ready;
  } kcsr_pulse_t;

  // static control levels
  typedef struct packed {
    logic fec_enable;
    logic fec_err_ind;
    logic fec_request;
    logic an_enable;
    logic user_base_page;
    logic user_next_page;
    logic remote_fault;
    logic force_nonce;
    logic param_override;
  } kcsr_ctrl_t;

endpackage

// [hw/kcsr_pulse.sv]
// module: self-clearing action bit that issues a one-cycle pulse
module kcsr_pulse (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // request and qualifier
  input  wire logic set_i,
  input  wire logic allow_i,
  // pulse out
  output logic      pulse_o
);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= set_i & allow_i;
    end
  end

endmodule

// [hw/kcsr_top.sv]
// module: sequencer, fec and auto-negotiation control/status registers
// Behaviour
// - fec enable bit switches fec; resets to the fec default parameter.
// - error-indication enable bit forwards fec decode errors to pcs.
// - link-ready status follows the sequencer link-ready signal.
// - negotiation timeout latches high, clears on negotiation restart unless a timeout arrives in that cycle.
// - training timeout status set when sequencer reports training timeout.
// - six-bit mode field reports sequencer pcs mode, one bit each.
// - fec ability bit fixed by the fec build parameter.
// - error-indication ability bit reads 1 when errors can be reported.
// - writing 1 injects one transmit fec error pulse, then clears.
// - reserved word range stays unimplemented, reads zero.
// - negotiation enable bit enables negotiation, resets to 1.
// - base-page bit selects user base pages over generated ones.
// - next-page bit selects user next pages over null messages.
// - remote-fault bit advertises remote fault in negotiation pages.
// - nonce-force bit forces the transmitted nonce to a fixed value.
// - override bit takes advertised values from override bits.
// - writing 1 resets all negotiation state machines, then clears.
// - transmit restart pulses only while tx machine negotiates; clears.
// - next-page-ready sends extended next page, then clears.
// - writing 1 restarts sequencer and pcs reconfiguration, then clears.
module kcsr_top
  import kcsr_pkg::*;
#(
  parameter logic fec_default_param = 1'b1,
  parameter logic fec_build_param   = 1'b1,
  parameter logic err_ind_ability   = 1'b1
) (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // management port
  input  wire logic [10:0]          ADDRESS,
  input  wire logic                 WRITE,
  input  wire logic                 READ,
  input  wire logic [31:0]          WRITEDATA,
  output logic      [31:0]          READDATA,
  output logic                      READDATAVALID,
  // sequencer status
  input  wire logic                 SEQ_LINK_READY,
  input  wire logic                 NEGOTIATION_TIMEOUT_FLAG,
  input  wire logic                 TRAINING_TIMEOUT_FLAG,
  input  wire logic [5:0]           SEQ_MODE,
  input  wire logic                 SEQ_AN_RESTARTED,
  input  wire logic                 TX_SM_IN_AN,
  // control levels and action pulses
  output kcsr_pkg::kcsr_ctrl_t      CTRL,
  output kcsr_pkg::kcsr_pulse_t     PULSE
);
  import kcsr_pkg::*;

  // ===========================================================
  // request decode
  kcsr_req_t req;
  assign req = '{addr: ADDRESS, wdata: WRITEDATA, wr: WRITE, rd: READ};

  logic wr_fec;
  logic wr_inj;
  logic wr_anc;
  logic wr_act;
  assign wr_fec = req.wr & (req.addr == ADDR_FEC_CTRL);
  assign wr_inj = req.wr & (req.addr == ADDR_FEC_INJ);
  assign wr_anc = req.wr & (req.addr == ADDR_AN_CTRL);
  assign wr_act = req.wr & (req.addr == ADDR_AN_ACT);

  // ===========================================================
  // status capture
  kcsr_seq_t seq_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      seq_q <= '0;
    end else begin
      seq_q.link_ready <= SEQ_LINK_READY;
      seq_q.lt_timeout <= TRAINING_TIMEOUT_FLAG;
      seq_q.mode       <= SEQ_MODE;
      if (NEGOTIATION_TIMEOUT_FLAG) begin
        seq_q.an_timeout <= 1'b1;
      end else if (SEQ_AN_RESTARTED) begin
        seq_q.an_timeout <= 1'b0;
      end
    end
  end

  // ===========================================================
  // control registers
  kcsr_ctrl_t ctrl_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_q                <= '0;
      ctrl_q.fec_enable     <= fec_default_param;
      ctrl_q.an_enable      <= AN_EN_RST;
    end else begin
      if (wr_fec) begin
        ctrl_q.fec_enable  <= req.wdata[B_FEC_EN];
        ctrl_q.fec_err_ind <= req.wdata[B_FEC_ERR_IND];
        ctrl_q.fec_request <= req.wdata[B_FEC_REQ];
      end
      if (wr_anc) begin
        ctrl_q.an_enable      <= req.wdata[B_AN_EN];
        ctrl_q.user_base_page <= req.wdata[B_BASE_PG];
        ctrl_q.user_next_page <= req.wdata[B_NEXT_PG];
        ctrl_q.remote_fault   <= req.wdata[B_RFAULT];
        ctrl_q.force_nonce    <= req.wdata[B_NONCE];
        ctrl_q.param_override <= req.wdata[B_OVERRIDE];
      end
    end
  end
  assign CTRL = ctrl_q;

  // ===========================================================
  // action pulses
  logic p_seq;
  logic p_inj;
  logic p_anr;
  logic p_txr;
  logic p_np;

  kcsr_pulse u_seq (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .set_i   (wr_fec & req.wdata[B_SEQ_RESTART]),
    .allow_i (1'b1),
    .pulse_o (p_seq)
  );
  kcsr_pulse u_inj (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .set_i   (wr_inj & req.wdata[B_FEC_INJ]),
    .allow_i (1'b1),
    .pulse_o (p_inj)
  );
  kcsr_pulse u_anr (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .set_i   (wr_act & req.wdata[B_AN_RESET]),
    .allow_i (1'b1),
    .pulse_o (p_anr)
  );
  kcsr_pulse u_txr (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .set_i   (wr_act & req.wdata[B_TX_RESTART]),
    .allow_i (TX_SM_IN_AN),
    .pulse_o (p_txr)
  );
  kcsr_pulse u_np (
    .CLOCK   (CLOCK),
    .RST     (RST),
    .set_i   (wr_act & req.wdata[B_NP_READY]),
    .allow_i (1'b1),
    .pulse_o (p_np)
  );

  assign PULSE = '{seq_restart: p_seq, fec_inject: p_inj, an_reset: p_anr,
                   tx_restart: p_txr, np_ready: p_np};

  // ===========================================================
  // read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = ZERO32;
    case (req.addr)
      ADDR_FEC_CTRL: begin
        rd_d[B_FEC_EN]      = ctrl_q.fec_enable;
        rd_d[B_FEC_ERR_IND] = ctrl_q.fec_err_ind;
        rd_d[B_FEC_REQ]     = ctrl_q.fec_request;
      end
      ADDR_SEQ_STAT: begin
        rd_d[B_LINK_READY]  = seq_q.link_ready;
        rd_d[B_AN_TMO]      = seq_q.an_timeout;
        rd_d[B_LT_TMO]      = seq_q.lt_timeout;
        rd_d[B_MODE_LO +: MODE_W] = seq_q.mode;
        rd_d[B_FEC_ABIL]    = fec_build_param;
        rd_d[B_ERRIND_ABIL] = err_ind_ability;
      end
      ADDR_AN_CTRL: begin
        rd_d[B_AN_EN]    = ctrl_q.an_enable;
        rd_d[B_BASE_PG]  = ctrl_q.user_base_page;
        rd_d[B_NEXT_PG]  = ctrl_q.user_next_page;
        rd_d[B_RFAULT]   = ctrl_q.remote_fault;
        rd_d[B_NONCE]    = ctrl_q.force_nonce;
        rd_d[B_OVERRIDE] = ctrl_q.param_override;
      end
      default: begin
        rd_d = ZERO32;
      end
    endcase
  end

  logic [31:0] rdata_q;
  logic        rvalid_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_q  <= ZERO32;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rd_d;
      end
    end
  end
  assign READDATA      = rdata_q;
  assign READDATAVALID = rvalid_q;

endmodule

// [sim/kcsr_top_monitor.sv]
// checker: port timing of the csr slice
module kcsr_mon
  import kcsr_pkg::*;
#(
  parameter logic fec_default_param = 1'b1
) (
  // clock and reset
  input wire logic                  CLOCK,
  input wire logic                  RST,
  // management port
  input wire logic [10:0]           ADDRESS,
  input wire logic                  WRITE,
  input wire logic                  READ,
  input wire logic [31:0]           WRITEDATA,
  input wire logic [31:0]           READDATA,
  input wire logic                  READDATAVALID,
  // sequencer status
  input wire logic                  SEQ_LINK_READY,
  input wire logic                  NEGOTIATION_TIMEOUT_FLAG,
  input wire logic                  TRAINING_TIMEOUT_FLAG,
  input wire logic [5:0]            SEQ_MODE,
  input wire logic                  SEQ_AN_RESTARTED,
  input wire logic                  TX_SM_IN_AN,
  // controls and pulses
  input wire kcsr_pkg::kcsr_ctrl_t  CTRL,
  input wire kcsr_pkg::kcsr_pulse_t PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  wire logic  wa = WRITE && ADDRESS == ADDR_AN_ACT;
  wire logic  wf = WRITE && ADDRESS == ADDR_FEC_CTRL;
  wire logic  wi = WRITE && ADDRESS == ADDR_FEC_INJ && WRITEDATA[B_FEC_INJ];
  logic [31:0] wd_q;
  always_ff @(posedge CLOCK) begin
    wd_q <= WRITEDATA;
  end
  // ==========================================
  // assertions
  chk_reset_vals: assert property (
    $fell(RST) |-> CTRL.fec_enable == fec_default_param && CTRL.an_enable)
    else $error("control reset values wrong");
  chk_fec_ctrl: assert property (
    wf |=> {CTRL.fec_request, CTRL.fec_err_ind, CTRL.fec_enable}
      == wd_q[18:16]) else $error("fec control write lost");
  chk_an_ctrl: assert property (
    WRITE && ADDRESS == ADDR_AN_CTRL |=> {CTRL.param_override,
      CTRL.force_nonce, CTRL.remote_fault, CTRL.user_next_page,
      CTRL.user_base_page, CTRL.an_enable} == wd_q[5:0])
    else $error("negotiation control write lost");
  chk_seq_restart: assert property (
    wf |=> PULSE.seq_restart == wd_q[0]) else $error("restart pulse wrong");
  chk_fec_inject: assert property (
    wi |=> PULSE.fec_inject ##1 (!PULSE.fec_inject || $past(wi)))
    else $error("inject pulse wrong");
  chk_fec_stray: assert property (
    !wi && !wf |=> !PULSE.fec_inject && !PULSE.seq_restart)
    else $error("fec pulse without write");
  chk_an_pulses: assert property (
    wa |=> PULSE.an_reset == wd_q[0] && PULSE.np_ready == wd_q[8])
    else $error("negotiation pulses wrong");
  chk_tx_gate: assert property (
    wa |=> PULSE.tx_restart == (wd_q[4] && $past(TX_SM_IN_AN)))
    else $error("tx restart gating wrong");
  chk_no_stray: assert property (
    !wa |=> !PULSE.an_reset && !PULSE.tx_restart && !PULSE.np_ready)
    else $error("action pulse without write");
  chk_rsvd_read: assert property (
    READ && ADDRESS >= ADDR_RSVD_LO && ADDRESS <= ADDR_RSVD_HI
      |=> READDATAVALID && READDATA == 32'h0)
    else $error("reserved read not zero");
endmodule

bind kcsr_top kcsr_mon #(.fec_default_param(fec_default_param)) u_mon (
  .CLOCK(CLOCK), .RST(RST), .ADDRESS(ADDRESS), .WRITE(WRITE),
  .READ(READ), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
  .READDATAVALID(READDATAVALID), .SEQ_LINK_READY(SEQ_LINK_READY),
  .NEGOTIATION_TIMEOUT_FLAG(NEGOTIATION_TIMEOUT_FLAG), .TRAINING_TIMEOUT_FLAG(TRAINING_TIMEOUT_FLAG),
  .SEQ_MODE(SEQ_MODE), .SEQ_AN_RESTARTED(SEQ_AN_RESTARTED),
  .TX_SM_IN_AN(TX_SM_IN_AN), .CTRL(CTRL), .PULSE(PULSE));

// [sim/kcsr_top_tb.sv]
// testbench: random and corner register traffic for the csr slice
module kcsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kcsr_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic [10:0] ADDRESS = 11'h0;
  logic        WRITE = 1'b0;
  logic        READ = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic        READDATAVALID;
  logic        SEQ_LINK_READY = 1'b0;
  logic        NEGOTIATION_TIMEOUT_FLAG = 1'b0;
  logic        TRAINING_TIMEOUT_FLAG = 1'b0;
  logic [5:0]  SEQ_MODE = 6'h0;
  logic        SEQ_AN_RESTARTED = 1'b0;
  logic        TX_SM_IN_AN = 1'b0;
  kcsr_ctrl_t  CTRL;
  kcsr_pulse_t PULSE;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h8a45;
  logic [31:0] d;
  logic        an_lat = 1'b0;
  // build choices of the instance; fec ability deliberately off
  localparam logic fec_build = 1'b0;
  localparam logic err_abil  = 1'b1;

  always #5 CLOCK = ~CLOCK;

  kcsr_top #(
    .fec_default_param (1'b0),
    .fec_build_param   (fec_build),
    .err_ind_ability   (err_abil)
  ) dut (
    .CLOCK(CLOCK), .RST(RST), .ADDRESS(ADDRESS), .WRITE(WRITE),
    .READ(READ), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .READDATAVALID(READDATAVALID), .SEQ_LINK_READY(SEQ_LINK_READY),
    .NEGOTIATION_TIMEOUT_FLAG(NEGOTIATION_TIMEOUT_FLAG), .TRAINING_TIMEOUT_FLAG(TRAINING_TIMEOUT_FLAG),
    .SEQ_MODE(SEQ_MODE), .SEQ_AN_RESTARTED(SEQ_AN_RESTARTED),
    .TX_SM_IN_AN(TX_SM_IN_AN), .CTRL(CTRL), .PULSE(PULSE));

  // ==========================================
  // helpers
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_stat(logic [31:0] v, logic a);
    return {14'h0, err_abil, fec_build, 2'h0, v[13:8], 5'h0, v[3], a, v[0]};
  endfunction
  function automatic logic [31:0] exp_ctrl(logic [31:0] v);
    return {23'h0, v[16], v[17], v[18], v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [31:0] v);
    @(negedge CLOCK);
    ADDRESS = a;
    WRITEDATA = v;
    WRITE = 1'b1;
    @(negedge CLOCK);
    WRITE = 1'b0;
  endtask
  task automatic rdc(string n, logic [10:0] a, logic [31:0] e);
    @(negedge CLOCK);
    ADDRESS = a;
    READ = 1'b1;
    @(negedge CLOCK);
    READ = 1'b0;
    chk("valid", 32'h1, {31'h0, READDATAVALID});
    chk(n, e, READDATA);
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // ==========================================
  // scenarios
  initial begin
    repeat (20) @(negedge CLOCK);
    RST = 1'b0;
    rdc("fec_rst", ADDR_FEC_CTRL, 32'h0);
    rdc("an_rst", ADDR_AN_CTRL, 32'h1);
    for (int i = 0; i < 12; i++) begin
      d = (i < 2) ? {32{i[0]}} : nxt();
      wr(ADDR_AN_CTRL, d);
      wr(ADDR_FEC_CTRL, d);
      chk("restart", {31'h0, d[0]}, {31'h0, PULSE.seq_restart});
      chk("ctrl", exp_ctrl(d), {23'h0, CTRL});
      rdc("an_ctrl", ADDR_AN_CTRL, d & 32'h3f);
      rdc("fec_ctrl", ADDR_FEC_CTRL, d & 32'h7_0000);
    end
    // software side: restart after a request change or an override enable
    wr(ADDR_FEC_CTRL, 32'h4_0000);
    wr(ADDR_FEC_CTRL, 32'h4_0001);
    chk("req_restart", 32'h1, {31'h0, PULSE.seq_restart});
    chk("req_kept", 32'h1, {31'h0, CTRL.fec_request});
    wr(ADDR_AN_CTRL, 32'h21);
    wr(ADDR_FEC_CTRL, 32'h1);
    chk("ovr_restart", 32'h1, {31'h0, PULSE.seq_restart});
    chk("ovr_kept", 32'h1, {31'h0, CTRL.param_override});
    for (logic [10:0] a = ADDR_RSVD_LO; a <= ADDR_RSVD_HI; a++) begin
      wr(a, 32'hffff_ffff);
      rdc("rsvd", a, 32'h0);
    end
    rdc("unmapped", 11'h7ff, 32'h0);
    for (int t = 0; t < 2; t++) begin
      TX_SM_IN_AN = t[0];
      wr(ADDR_AN_ACT, 32'h111);
      chk("act", {29'h0, 1'b1, t[0], 1'b1}, {29'h0, PULSE[2:0]});
      rdc("act_rd", ADDR_AN_ACT, 32'h0);
    end
    wr(ADDR_FEC_INJ, 32'h800);
    chk("inject", 32'h1, {31'h0, PULSE.fec_inject});
    rdc("inj_rd", ADDR_FEC_INJ, 32'h0);
    wr(ADDR_SEQ_STAT, 32'hffff_ffff);
    for (int i = 0; i < 10; i++) begin
      d = nxt();
      // corner: make sure the timeout latch is set at least once
      if (i == 0) d[2:1] = 2'b11;
      SEQ_LINK_READY = d[0];
      NEGOTIATION_TIMEOUT_FLAG = d[1] & d[2];
      TRAINING_TIMEOUT_FLAG = d[3];
      SEQ_MODE = d[13:8];
      an_lat |= d[1] & d[2];
      repeat (2) @(negedge CLOCK);
      NEGOTIATION_TIMEOUT_FLAG = 1'b0;
      repeat (2) @(negedge CLOCK);
      rdc("status", ADDR_SEQ_STAT, exp_stat(d, an_lat));
    end
    SEQ_AN_RESTARTED = 1'b1;
    @(negedge CLOCK);
    SEQ_AN_RESTARTED = 1'b0;
    repeat (2) @(negedge CLOCK);
    rdc("an_clr", ADDR_SEQ_STAT, exp_stat(d, 1'b0));
    RST = 1'b1;
    repeat (2) @(negedge CLOCK);
    RST = 1'b0;
    rdc("an_rst2", ADDR_AN_CTRL, 32'h1);
    final_report();
  end
endmodule
